// *** inc/fcd_defs.svh ***
// constants of the memory timing clock divider: offsets, fields, resets
// assumes a 32-bit classic wishbone bus with one register per aligned word
`ifndef FCD_DEFS_SVH
`define FCD_DEFS_SVH

// register indices; byte address is four times the index
`define FCD_DIV_INDEX      2'h0
`define FCD_STATUS_INDEX   2'h1
`define FCD_TICKS_INDEX    2'h2
`define FCD_INDEX_W        2

// field positions of the divider register
`define FCD_LOADED_BIT     7
`define FCD_PRESCALE_BIT   6
`define FCD_RATIO_MSB      5
`define FCD_RATIO_W        6

// field positions of the status register
`define FCD_RUNNING_BIT    0
`define FCD_REJECTED_BIT   1

// reset values
`define FCD_DIV_RESET      8'h00
`define FCD_TICKS_RESET    16'h0000
`define FCD_TICKS_W        16

// prescaler divides by eight: counts 0..7
`define FCD_PRESCALE_LIMIT 3'h7
`define FCD_PRESCALE_W     3

// largest overall ratio, prescaler times divider field plus one
`define FCD_MAX_RATIO      512

`endif

// *** inc/fcd_pkg.sv ***
// types of the memory timing clock divider
// assumes fcd_defs.svh is on the include path
`include "fcd_defs.svh"

package fcd_pkg;

   typedef struct packed
   {
      logic                        prescaleByEightEnable;
      logic [`FCD_RATIO_W-1:0]     dividerRatioField;
   } fcd_div_cfg_t;

   typedef enum logic {
      FCD_BUS_IDLE,
      FCD_BUS_ACK
   } fcd_bus_state_t;

endpackage : fcd_pkg

// *** rtl/fcd_count_divider.sv ***
// counting divider: one tick every (limit + 1) steps
// assumes step is a single-cycle qualifier in the same clock domain
`timescale 1ns/1ps
`include "fcd_defs.svh"

module fcd_count_divider
#(
   parameter int WIDTH = `FCD_RATIO_W
)
(
   input  wire logic             clock,
   input  wire logic             reset,
   input  wire logic             run,
   input  wire logic             step,
   input  wire logic [WIDTH-1:0] limit,
   output logic                  tick
);

   logic [WIDTH-1:0] count;
   logic [WIDTH-1:0] next_count;
   logic             next_tick;

   always_comb
   begin
      next_count = count;
      next_tick  = 1'b0;
      if (!run)
      begin
         next_count = '0;
      end
      else if (step)
      begin
         if (count == limit)
         begin
            // ratio is limit plus one steps
            next_count = '0;
            next_tick  = 1'b1;
         end
         else
         begin
            next_count = count + WIDTH'(1);
         end
      end
   end

   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         count <= '0;
         tick  <= 1'b0;
      end
      else
      begin
         count <= next_count;
         tick  <= next_tick;
      end
   end

endmodule : fcd_count_divider

// *** rtl/fcd_clock_divider.sv ***
// memory timing clock divider with a write-once divider register
// assumes clock is the oscillator clock and a classic wishbone master
`timescale 1ns/1ps
`include "fcd_defs.svh"

module fcd_clock_divider
#(
   parameter int ADDR_W = 4
)
(
   input  wire logic              clock,
   input  wire logic              reset,
   input  wire logic              wbCycI,
   input  wire logic              wbStbI,
   input  wire logic              wbWeI,
   input  wire logic [ADDR_W-1:0] wbAdrI,
   input  wire logic [3:0]        wbSelI,
   input  wire logic [31:0]       wbDatI,
   output logic      [31:0]       wbDatO,
   output logic                   wbAckO,
   output logic                   timingTick,
   output logic                   dividerLoadedFlag,
   output logic                   prescaleByEightEnable,
   output logic      [5:0]        dividerRatioField
);

   // bus handshake state
   fcd_pkg::fcd_bus_state_t busState;
   fcd_pkg::fcd_bus_state_t next_busState;
   logic [31:0]             next_wbDatO;
   logic                    accept;
   logic                    writeLow;
   logic [`FCD_INDEX_W-1:0] regIndex;
   logic                    upperZero;

   // divider register state
   fcd_pkg::fcd_div_cfg_t   divCfg;
   fcd_pkg::fcd_div_cfg_t   next_divCfg;
   logic                    loaded;
   logic                    next_loaded;
   logic                    rejected;
   logic                    next_rejected;

   // time base state
   logic                    preTick;
   logic                    mainStep;
   logic                    mainTick;
   logic [`FCD_TICKS_W-1:0] tickCount;
   logic [`FCD_TICKS_W-1:0] next_tickCount;

   // address above the index field must be zero to hit a register
   assign regIndex  = wbAdrI[`FCD_INDEX_W+1:2];
   assign upperZero = (ADDR_W > `FCD_INDEX_W + 2) ?
                      ((wbAdrI >> (`FCD_INDEX_W + 2)) == '0) : 1'b1;

   // a request is taken once, in the cycle before ack rises
   assign accept    = wbCycI && wbStbI && (busState == fcd_pkg::FCD_BUS_IDLE);
   assign writeLow  = accept && wbWeI && wbSelI[0] && upperZero;

   always_comb
   begin
      next_busState = fcd_pkg::FCD_BUS_IDLE;
      next_wbDatO   = wbDatO;
      if (accept)
      begin
         // unmapped offsets still answer, reading zero
         next_busState = fcd_pkg::FCD_BUS_ACK;
         next_wbDatO   = 32'h00000000;
         if (!wbWeI && upperZero)
         begin
            case (regIndex)
               `FCD_DIV_INDEX:
               begin
                  next_wbDatO[`FCD_LOADED_BIT]     = loaded;
                  next_wbDatO[`FCD_PRESCALE_BIT]   = divCfg.prescaleByEightEnable;
                  next_wbDatO[`FCD_RATIO_MSB:0]    = divCfg.dividerRatioField;
               end
               `FCD_STATUS_INDEX:
               begin
                  next_wbDatO[`FCD_RUNNING_BIT]  = loaded;
                  next_wbDatO[`FCD_REJECTED_BIT] = rejected;
               end
               `FCD_TICKS_INDEX:
               begin
                  next_wbDatO[`FCD_TICKS_W-1:0] = tickCount;
               end
               default:
               begin
                  next_wbDatO = 32'h00000000;
               end
            endcase
         end
      end
   end

   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         busState <= fcd_pkg::FCD_BUS_IDLE;
         wbAckO   <= 1'b0;
         wbDatO   <= 32'h00000000;
      end
      else
      begin
         busState <= next_busState;
         wbAckO   <= (next_busState == fcd_pkg::FCD_BUS_ACK);
         wbDatO   <= next_wbDatO;
      end
   end

   // divider register: configuration takes only the first write with byte lane 0 selected
   always_comb
   begin
      next_divCfg   = divCfg;
      next_loaded   = loaded;
      next_rejected = rejected;
      if (writeLow && (regIndex == `FCD_DIV_INDEX))
      begin
         if (!loaded)
         begin
            next_divCfg.prescaleByEightEnable = wbDatI[`FCD_PRESCALE_BIT];
            next_divCfg.dividerRatioField     = wbDatI[`FCD_RATIO_MSB:0];
         end
         else
         begin
            // late writes are dropped; software can see it here
            next_rejected = 1'b1;
         end
         // bit 7 of the data is ignored; any write with byte lane 0 selected sets the flag
         next_loaded = 1'b1;
      end
      else if (writeLow && (regIndex == `FCD_STATUS_INDEX)
               && wbDatI[`FCD_REJECTED_BIT])
      begin
         next_rejected = 1'b0;
      end
      // a rejected write in the clearing cycle is not reachable: both
      // hit different indices, so one bus access cannot do both
   end

   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         divCfg   <= fcd_pkg::fcd_div_cfg_t'(7'(`FCD_DIV_RESET));
         loaded   <= 1'b0;
         rejected <= 1'b0;
      end
      else
      begin
         divCfg   <= next_divCfg;
         loaded   <= next_loaded;
         rejected <= next_rejected;
      end
   end

   // mirror of the configuration for the downstream algorithm engine
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         dividerLoadedFlag     <= 1'b0;
         prescaleByEightEnable <= 1'b0;
         dividerRatioField     <= '0;
      end
      else
      begin
         dividerLoadedFlag     <= next_loaded;
         prescaleByEightEnable <= next_divCfg.prescaleByEightEnable;
         dividerRatioField     <= next_divCfg.dividerRatioField;
      end
   end

   // prescaler: one step every eight oscillator cycles
   fcd_count_divider
   #(
      .WIDTH (`FCD_PRESCALE_W)
   )
   u_prescale
   (
      .clock (clock),
      .reset (reset),
      .run   (loaded && divCfg.prescaleByEightEnable),
      .step  (1'b1),
      .limit (`FCD_PRESCALE_LIMIT),
      .tick  (preTick)
   );

   // bypass feeds the oscillator straight into the divider
   assign mainStep = divCfg.prescaleByEightEnable ? preTick : 1'b1;

   // 6-bit field plus one gives 64 at most; with 8 that is 512
   fcd_count_divider
   #(
      .WIDTH (`FCD_RATIO_W)
   )
   u_main
   (
      .clock (clock),
      .reset (reset),
      .run   (loaded),
      .step  (mainStep),
      .limit (divCfg.dividerRatioField),
      .tick  (mainTick)
   );

   // time base stays idle until configured, so no unknown rate escapes
   always_comb
   begin
      next_tickCount = tickCount;
      if (mainTick)
      begin
         next_tickCount = tickCount + `FCD_TICKS_W'(1);
      end
   end

   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         tickCount  <= `FCD_TICKS_RESET;
         timingTick <= 1'b0;
      end
      else
      begin
         tickCount  <= next_tickCount;
         // one pulse per divided period drives the timed events
         timingTick <= mainTick;
      end
   end

endmodule : fcd_clock_divider

// *** sim/fcd_chk.sv ***
// checker for the divider register and the time base
// sees only the ports of fcd_clock_divider; bound from the bench
`timescale 1ns/1ps
module fcd_chk
#(parameter int ADDR_W = 4)
(
   input wire logic              clock,
   input wire logic              reset,
   input wire logic              wbCycI,
   input wire logic              wbStbI,
   input wire logic              wbWeI,
   input wire logic [ADDR_W-1:0] wbAdrI,
   input wire logic [3:0]        wbSelI,
   input wire logic [31:0]       wbDatI,
   input wire logic [31:0]       wbDatO,
   input wire logic              wbAckO,
   input wire logic              timingTick,
   input wire logic              dividerLoadedFlag,
   input wire logic              prescaleByEightEnable,
   input wire logic [5:0]        dividerRatioField
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   logic [9:0] gap;
   logic       seen;
   logic [9:0] period;
   // saturates so a lost tick cannot wrap into a false match
   assign period = (prescaleByEightEnable ? 10'h008 : 10'h001) *
                   ({4'h0, dividerRatioField} + 10'h001);
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         gap  <= 10'h000;
         seen <= 1'b0;
      end
      else if (timingTick)
      begin
         gap  <= 10'h001;
         seen <= 1'b1;
      end
      else if (gap != 10'h3FF)
         gap <= gap + 10'h001;
   end
   sequence s_req;
      wbCycI && wbStbI && !wbAckO;
   endsequence
   sequence s_acc(logic w, logic [1:0] i);
      wbCycI && wbStbI && wbAckO && wbWeI == w && wbAdrI[3:2] == i;
   endsequence
   a_ack_answer: assert property (s_req |=> wbAckO) else $error("ack late");
   a_ack_pulse: assert property (wbAckO |=> !wbAckO) else $error("ack held");
   a_flag_set: assert property (s_acc(1'b1, 2'h0) ##0 wbSelI[0] |-> dividerLoadedFlag)
      else $error("flag not set");
   a_flag_sticky: assert property (dividerLoadedFlag |=> dividerLoadedFlag)
      else $error("flag lost");
   a_cfg_frozen: assert property (dividerLoadedFlag |=>
      $stable({prescaleByEightEnable, dividerRatioField})) else $error("config moved");
   a_no_early: assert property (!dividerLoadedFlag |-> !timingTick)
      else $error("tick before load");
   a_div_read: assert property (s_acc(1'b0, 2'h0) |-> wbDatO == {24'h000000,
      dividerLoadedFlag, prescaleByEightEnable, dividerRatioField}) else $error("bad read");
   a_unmapped_zero: assert property (s_acc(1'b0, 2'h3) |-> wbDatO == 32'h00000000)
      else $error("unmapped data");
   a_tick_period: assert property (timingTick && seen |-> gap == period)
      else $error("tick period");
endmodule : fcd_chk

// *** sim/testbench.sv ***
// random and corner tests of the divider over classic wishbone
// assumes fcd_clock_divider with default ADDR_W and the fcd_chk checker
`timescale 1ns/1ps
module testbench;
   logic        clock, reset, wbCycI, wbStbI, wbWeI, wbAckO;
   logic [3:0]  wbAdrI, wbSelI;
   logic [31:0] wbDatI, wbDatO, got, rnd, d;
   logic        timingTick, dividerLoadedFlag, prescaleByEightEnable, pre;
   logic [5:0]  dividerRatioField, ratio;
   int          fail_count, compares, seed, n;
   logic [15:0] tickSeen;
   fcd_clock_divider dut (.clock, .reset, .wbCycI, .wbStbI, .wbWeI, .wbAdrI, .wbSelI,
      .wbDatI, .wbDatO, .wbAckO, .timingTick, .dividerLoadedFlag, .prescaleByEightEnable,
      .dividerRatioField);
   function automatic logic [31:0] expN(logic p, logic [5:0] r);
      return (p ? 32'h8 : 32'h1) * ({26'h0, r} + 32'h1);
   endfunction : expN
   // bench count of tick pulses, to check the tick counter register
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
         tickSeen <= 16'h0000;
      else if (timingTick)
         tickSeen <= tickSeen + 16'h0001;
   end
   task automatic wrap_up();
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : wrap_up
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e)
      begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // idle edge first, so no strobe is set twice in one step
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] v,
                      input logic [3:0] s);
      @(posedge clock);
      wbCycI <= 1'b1;
      wbStbI <= 1'b1;
      wbWeI  <= w;
      wbAdrI <= a;
      wbDatI <= v;
      wbSelI <= s;
      // held until ack is seen high at a rising edge; the watchdog ends a hang
      do
         @(posedge clock);
      while (wbAckO !== 1'b1);
      got = wbDatO;
      wbCycI <= 1'b0;
      wbStbI <= 1'b0;
   endtask : bus
   task automatic measure();
      @(negedge clock);
      for (int i = 0; i < 600 && timingTick !== 1'b1; i++)
         @(negedge clock);
      @(negedge clock);
      n = 1;
      while (timingTick !== 1'b1 && n < 600)
      begin
         @(negedge clock);
         n++;
      end
   endtask : measure
   initial
   begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   initial
   begin
      #100000;
      fail_count++;
      wrap_up();
   end
   initial
   begin
      seed = 49;
      fail_count = 0;
      compares = 0;
      {wbCycI, wbStbI, wbWeI, wbAdrI, wbSelI, wbDatI} = '0;
      reset = 1'b1;
      // case 0 divides by one, case 1 by the full 512, the rest random
      for (int t = 0; t < 4; t++)
      begin
         repeat (8) @(posedge clock);
         reset <= 1'b0;
         rnd = $random(seed);
         pre = (t < 2) ? t[0] : rnd[6];
         ratio = (t == 0) ? 6'h00 : (t == 1) ? 6'h3F : rnd[5:0]; // band out of reach
         d = {rnd[31:7], pre, ratio};
         bus(1'b1, 4'hC, rnd, 4'hF);
         bus(1'b0, 4'hC, 32'h0, 4'hF);
         chk("unmapped", 32'h0, got);
         bus(1'b1, 4'h0, d, 4'hE);
         bus(1'b0, 4'h0, 32'h0, 4'hF);
         chk("div before load", 32'h0, got);
         bus(1'b0, 4'h4, 32'h0, 4'hF);
         chk("status before load", 32'h0, got);
         bus(1'b0, 4'h8, 32'h0, 4'hF);
         chk("ticks before load", 32'h0, got);
         bus(1'b1, 4'h0, d, 4'h1);
         bus(1'b1, 4'h0, ~d, 4'hF);
         bus(1'b0, 4'h0, 32'h0, 4'hF);
         chk("div loaded", {24'h0, 1'b1, pre, ratio}, got);
         bus(1'b0, 4'h4, 32'h0, 4'hF);
         chk("status rejected", 32'h3, got);
         bus(1'b1, 4'h4, 32'h2, 4'hF);
         bus(1'b0, 4'h4, 32'h0, 4'hF);
         chk("status cleared", 32'h1, got);
         measure();
         chk("tick period", expN(pre, ratio), n);
         bus(1'b0, 4'h8, 32'h0, 4'hF);
         chk("tick count", {16'h0000, tickSeen}, got);
         $display("test %0d done", t);
         @(posedge clock);
         reset <= 1'b1;
      end
      wrap_up();
   end
endmodule : testbench
bind fcd_clock_divider fcd_chk #(.ADDR_W(ADDR_W)) chk (.clock, .reset, .wbCycI, .wbStbI,
   .wbWeI, .wbAdrI, .wbSelI, .wbDatI, .wbDatO, .wbAckO, .timingTick, .dividerLoadedFlag,
   .prescaleByEightEnable, .dividerRatioField);
